// ===== rtl/ssc_map.svh
// Constant map for the serial synthesizer control register bank.
`ifndef SSC_MAP_SVH
`define SSC_MAP_SVH
`define SSC_WORD_BITS      22
`define SSC_DATA_BITS      18
`define SSC_ADDR_BITS      4
`define SSC_ADDR_MAIN      4'h0
`define SSC_ADDR_POWER     4'h2
`define SSC_ADDR_BAND1     4'h3
`define SSC_ADDR_BAND2     4'h4
`define SSC_AUX_SEL_HI     13
`define SSC_AUX_SEL_LO     12
`define SSC_REF_DIV_BIT    6
`define SSC_POWER_ON_BIT   0
`define SSC_BAND2_MSB      16
`define SSC_AUX_FORCE_LOW  2'h1
`define SSC_AUX_LOCK       2'h3
`define SSC_AUX_RESET      2'h0
`define SSC_REF_DIV_65     8'h41
`define SSC_REF_DIV_130    8'h82
`define SSC_MAIN_DEFAULT   18'h00002
`endif

// ===== rtl/ssc_pkg.sv
// Types shared by the serial synthesizer control register bank.
package ssc_pkg;
	typedef enum logic {
		SSC_BAND1,
		SSC_BAND2
	} ssc_band_t;

	typedef struct packed {
		logic [3:0]  addr;
		logic [17:0] data;
	} ssc_word_t;
endpackage : ssc_pkg

// ===== rtl/ssc_shifter.sv
// Serial-clock-domain shift register that captures the last word of a frame.
`timescale 1ns/1ps
`default_nettype none
`include "ssc_map.svh"
module ssc_shifter #(
	parameter int WORD_BITS = `SSC_WORD_BITS
) (
	// Link side.
	input  wire logic                 serial_clk_i,
	input  wire logic                 serial_latch_enable_n_i,
	input  wire logic                 serial_shift_input_i,
	// Captured word.
	output logic [WORD_BITS-1:0]      shift_word_o
);
	// Shifting happens only while latch enable is low, so the word holds until the next frame.
	always_ff @(posedge serial_clk_i) begin
		if (!serial_latch_enable_n_i) begin
			shift_word_o <= {shift_word_o[WORD_BITS-2:0], serial_shift_input_i};
		end
	end
endmodule : ssc_shifter
`default_nettype wire

// ===== rtl/ssc_regs.sv
// Write-only control register bank loaded over the three-wire serial port.
`timescale 1ns/1ps
`default_nettype none
`include "ssc_map.svh"
// What this block does
// - A 22-bit word of 4 address and 18 data bits shifts on rising serial clock while latch low.
// - The rising latch edge loads the addressed register; no shifting while latch is high.
// - Leading bits beyond the last 22 of a frame are ignored.
// - Address 0000 selects the main configuration register.
// - Address 0010 selects the power control register.
// - Address 0011 selects the first band divide value, all 18 bits.
// - Address 0100 selects the second band divide value in bits 16:0, bit 17 written as zero.
// - Aux select 01 drives the aux pin low; 00 and 10 are reserved.
// - Aux select 11 drives the active-low lock margin flag onto the aux pin.
// - Reference divider bit 6 picks divide by 65 when zero and 130 when one.
// - Power control bit 0 turns the synthesizer on when one, off when zero; bits 17:1 are zero.
module ssc_regs #(
	parameter int DATA_BITS = `SSC_DATA_BITS,
	parameter int ADDR_BITS = `SSC_ADDR_BITS
) (
	// System clock and reset.
	input  wire logic                 sys_clk_i,
	input  wire logic                 rstn_i,
	// Serial programming port.
	input  wire logic                 serial_clk_i,
	input  wire logic                 serial_latch_enable_n_i,
	input  wire logic                 serial_shift_input_i,
	// Status from the synthesizer core.
	input  wire logic                 lock_margin_flag_n_i,
	input  wire logic                 power_pin_n_i,
	// Control outputs.
	output logic                      aux_output_pin_o,
	output logic [7:0]                ref_divider_ratio_o,
	output logic                      ref_divider_select_o,
	output logic                      synth_power_on_o,
	output logic [DATA_BITS-1:0]      band1_divide_count_o,
	output logic [DATA_BITS-2:0]      band2_divide_count_o,
	output ssc_pkg::ssc_band_t        band_select_o,
	output logic                      write_strobe_o
);
	localparam int WORD_BITS = ADDR_BITS + DATA_BITS;

	logic [WORD_BITS-1:0]   link_word;
	logic [2:0]             latch_sync;
	logic [2:0]             flag_sync;
	logic [2:0]             pin_sync;
	logic [WORD_BITS-1:0]   word_s1;
	logic [WORD_BITS-1:0]   word_s2;
	logic                   latch_seen;
	logic                   word_take;
	logic [1:0]             aux_pin_function_select;
	logic                   power_control;
	ssc_pkg::ssc_word_t     rx;

	ssc_shifter #(
		.WORD_BITS(WORD_BITS)
	) u_shift (
		.serial_clk_i           (serial_clk_i),
		.serial_latch_enable_n_i(serial_latch_enable_n_i),
		.serial_shift_input_i   (serial_shift_input_i),
		.shift_word_o           (link_word)
	);

	// Latch, lock flag and power pin each pass three flops.
	// A change counts once the second and third flops agree; a low power pin counts as soon as the second flop sees it.
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			latch_sync <= 3'h7;
			flag_sync  <= 3'h7;
			pin_sync   <= 3'h0;
		end else begin
			latch_sync <= {latch_sync[1:0], serial_latch_enable_n_i};
			flag_sync  <= {flag_sync[1:0], lock_margin_flag_n_i};
			pin_sync   <= {pin_sync[1:0], power_pin_n_i};
		end
	end

	// The word is stable once latch enable is high, so it is sampled twice as a quiet bus.
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			word_s1 <= '0;
			word_s2 <= '0;
		end else begin
			word_s1 <= link_word;
			word_s2 <= word_s1;
		end
	end

	// Rising latch edge seen after the synchroniser agrees.
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			latch_seen <= 1'b1;
		end else if (latch_sync[2] == latch_sync[1]) begin
			latch_seen <= latch_sync[2];
		end
	end

	assign rx = ssc_pkg::ssc_word_t'(word_s2);

	// One take per frame: the synchronised latch is high now and was low before.
	assign word_take = !latch_seen && latch_sync[2] && latch_sync[1];

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			write_strobe_o <= 1'b0;
		end else begin
			write_strobe_o <= word_take;
		end
	end

	// Main configuration keeps only the fields it uses; reserved bits are dropped.
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			aux_pin_function_select <= `SSC_AUX_RESET;
			ref_divider_select_o    <= 1'b0;
		end else if (word_take && rx.addr == `SSC_ADDR_MAIN) begin
			aux_pin_function_select <= rx.data[`SSC_AUX_SEL_HI:`SSC_AUX_SEL_LO];
			ref_divider_select_o    <= rx.data[`SSC_REF_DIV_BIT];
		end
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			power_control <= 1'b0;
		end else if (word_take && rx.addr == `SSC_ADDR_POWER) begin
			power_control <= rx.data[`SSC_POWER_ON_BIT];
		end
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			band1_divide_count_o <= '0;
		end else if (word_take && rx.addr == `SSC_ADDR_BAND1) begin
			band1_divide_count_o <= rx.data;
		end
	end

	// Bit 17 of the second band word is reserved and not stored.
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			band2_divide_count_o <= '0;
		end else if (word_take && rx.addr == `SSC_ADDR_BAND2) begin
			band2_divide_count_o <= rx.data[`SSC_BAND2_MSB:0];
		end
	end

	// The last divide register written picks the band; other addresses leave it alone.
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			band_select_o <= ssc_pkg::SSC_BAND1;
		end else if (word_take) begin
			case (rx.addr)
				`SSC_ADDR_BAND1: begin
					band_select_o <= ssc_pkg::SSC_BAND1;
				end
				`SSC_ADDR_BAND2: begin
					band_select_o <= ssc_pkg::SSC_BAND2;
				end
				default: begin
				end
			endcase
		end
	end

	// The pin overrides the register bit when low.
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			synth_power_on_o <= 1'b0;
		end else begin
			synth_power_on_o <= power_control && pin_sync[2] && pin_sync[1];
		end
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ref_divider_ratio_o <= `SSC_REF_DIV_65;
		end else begin
			ref_divider_ratio_o <= ref_divider_select_o ? `SSC_REF_DIV_130 : `SSC_REF_DIV_65;
		end
	end

	// Reserved selections leave the pin low as well.
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			aux_output_pin_o <= 1'b0;
		end else if (aux_pin_function_select == `SSC_AUX_LOCK) begin
			if (flag_sync[2] == flag_sync[1]) begin
				aux_output_pin_o <= flag_sync[2];
			end
		end else if (aux_pin_function_select == `SSC_AUX_FORCE_LOW) begin
			aux_output_pin_o <= 1'b0;
		end else begin
			aux_output_pin_o <= 1'b0;
		end
	end
endmodule : ssc_regs
`default_nettype wire

// ===== testbench/ssc_regs_asserts.sv
// Port-level checks for the serial synthesizer control register bank.
`timescale 1ns/1ps
`default_nettype none
module ssc_regs_asserts #(
	parameter int DATA_BITS = 18
) (
	// Clock, reset and status inputs.
	input wire logic                 sys_clk_i,
	input wire logic                 rstn_i,
	input wire logic                 lock_margin_flag_n_i,
	input wire logic                 power_pin_n_i,
	// Control outputs.
	input wire logic                 aux_output_pin_o,
	input wire logic [7:0]           ref_divider_ratio_o,
	input wire logic                 ref_divider_select_o,
	input wire logic                 synth_power_on_o,
	input wire logic [DATA_BITS-1:0] band1_divide_count_o,
	input wire logic [DATA_BITS-2:0] band2_divide_count_o,
	input wire ssc_pkg::ssc_band_t   band_select_o,
	input wire logic                 write_strobe_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rstn_i);
	strobe_pulse_a: assert property (write_strobe_o |=> !write_strobe_o)
		else $error("write strobe longer than one cycle");
	ratio_map_a: assert property (ref_divider_ratio_o ==
		($past(ref_divider_select_o) ? 8'h82 : 8'h41)) else $error("ratio mismatch");
	select_hold_a: assert property (!$stable(ref_divider_select_o) |-> write_strobe_o)
		else $error("divider select moved without a write");
	band1_hold_a: assert property (!$stable(band1_divide_count_o) |-> write_strobe_o
		&& band_select_o == ssc_pkg::SSC_BAND1) else $error("band1 count moved wrongly");
	band2_hold_a: assert property (!$stable(band2_divide_count_o) |-> write_strobe_o
		&& band_select_o == ssc_pkg::SSC_BAND2) else $error("band2 count moved wrongly");
	band_sel_a: assert property (!$stable(band_select_o) |-> write_strobe_o)
		else $error("band select moved without a write");
	pin_off_a: assert property ((!power_pin_n_i) [*5] |-> !synth_power_on_o)
		else $error("power on while pin low");
	aux_flag_a: assert property ((!lock_margin_flag_n_i) [*5] |-> !aux_output_pin_o)
		else $error("aux pin high while flag low");
endmodule : ssc_regs_asserts
bind ssc_regs ssc_regs_asserts #(.DATA_BITS(DATA_BITS)) u_ssc_regs_asserts (.sys_clk_i,
	.rstn_i, .lock_margin_flag_n_i, .power_pin_n_i, .aux_output_pin_o, .ref_divider_ratio_o,
	.ref_divider_select_o, .synth_power_on_o, .band1_divide_count_o, .band2_divide_count_o,
	.band_select_o, .write_strobe_o);
`default_nettype wire

// ===== testbench/ssc_host.sv
// Behavioural host that programs the bank over the three-wire serial port.
`timescale 1ns/1ps
`default_nettype none
module ssc_host (
	// Serial programming port.
	output logic serial_clk_o = 1'b0,
	output logic latch_n_o    = 1'b1,
	output logic data_o       = 1'b0
);
	// Filler bits go first; the clock stands still outside frames.
	task automatic send(input logic [21:0] w, input int lead);
		int i;
		#5 latch_n_o = 1'b0;
		for (i = lead + 21; i >= 0; i--) begin
			data_o = (i > 21) ? ~w[21] : w[i];
			#24 serial_clk_o = 1'b1;
			#24 serial_clk_o = 1'b0;
		end
		#12 latch_n_o = 1'b1;
		data_o = ~data_o;
		#200;
	endtask : send
endmodule : ssc_host
`default_nettype wire

// ===== testbench/ssc_regs_tb.sv
// Self-checking bench for the serial synthesizer control register bank.
`timescale 1ns/1ps
`default_nettype none
module ssc_regs_tb;
	logic sys_clk_i = 1'b0, rstn_i = 1'b0, flag_n = 1'b1, pin_n = 1'b1;
	logic sclk, latch_n, serial_shift_input, aux, rsel, pwr, strobe;
	logic [7:0] ratio;
	logic [17:0] b1;
	logic [16:0] b2;
	ssc_pkg::ssc_band_t band;
	int error_cnt = 0, n_checks = 0, cyc = 0, k, n_strobe = 0;
	initial forever #4 sys_clk_i = ~sys_clk_i;
	ssc_host u_ssc_host (.serial_clk_o(sclk), .latch_n_o(latch_n), .data_o(serial_shift_input));
	ssc_regs u_ssc_regs (.sys_clk_i, .rstn_i, .serial_clk_i(sclk), .serial_latch_enable_n_i(latch_n),
		.serial_shift_input_i(serial_shift_input), .lock_margin_flag_n_i(flag_n), .power_pin_n_i(pin_n),
		.aux_output_pin_o(aux), .ref_divider_ratio_o(ratio), .ref_divider_select_o(rsel),
		.synth_power_on_o(pwr), .band1_divide_count_o(b1), .band2_divide_count_o(b2),
		.band_select_o(band), .write_strobe_o(strobe));
	task automatic chk(input string what, input logic [46:0] s, input logic [46:0] e);
		n_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", what, e, s);
		end
	endtask : chk
	task automatic expect_out(input logic [7:0] r, input logic a, input logic p,
		input logic [17:0] e1, input logic [16:0] e2, input logic bs);
		@(negedge sys_clk_i);
		chk("outputs", {ratio, rsel, aux, pwr, b1, b2, band}, {r, r == 8'h82, a, p, e1, e2, bs});
	endtask : expect_out
	task automatic final_report;
		$display("Checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : final_report
	always @(posedge sys_clk_i) begin
		cyc <= cyc + 1;
		if (strobe === 1'b1) begin
			n_strobe <= n_strobe + 1;
		end
		if (cyc == 8000) begin
			error_cnt++;
			final_report();
		end
	end
	initial begin
		repeat (2) @(posedge sys_clk_i);
		rstn_i <= 1'b1;
		@(posedge sys_clk_i);
		expect_out(8'h41, 1'b0, 1'b0, 18'h0, 17'h0, 1'b0);
		u_ssc_host.send({4'h0, 18'h00042}, 3);
		expect_out(8'h82, 1'b0, 1'b0, 18'h0, 17'h0, 1'b0);
		for (k = 0; k < 4; k++) begin
			u_ssc_host.send({4'h0, 4'h0, 2'(k), 12'h002}, 0);
			expect_out(8'h41, k == 3, 1'b0, 18'h0, 17'h0, 1'b0);
		end
		@(posedge sys_clk_i);
		flag_n <= 1'b0;
		repeat (8) @(posedge sys_clk_i);
		expect_out(8'h41, 1'b0, 1'b0, 18'h0, 17'h0, 1'b0);
		$display("Test main configuration done");
		u_ssc_host.send({4'h2, 18'h00001}, 1);
		expect_out(8'h41, 1'b0, 1'b1, 18'h0, 17'h0, 1'b0);
		@(posedge sys_clk_i);
		pin_n <= 1'b0;
		repeat (8) @(posedge sys_clk_i);
		expect_out(8'h41, 1'b0, 1'b0, 18'h0, 17'h0, 1'b0);
		@(posedge sys_clk_i);
		pin_n <= 1'b1;
		u_ssc_host.send({4'h2, 18'h00000}, 0);
		expect_out(8'h41, 1'b0, 1'b0, 18'h0, 17'h0, 1'b0);
		$display("Test power control done");
		u_ssc_host.send({4'h3, 18'h2A5F3}, 0);
		expect_out(8'h41, 1'b0, 1'b0, 18'h2A5F3, 17'h0, 1'b0);
		u_ssc_host.send({4'h4, 18'h12345}, 2);
		expect_out(8'h41, 1'b0, 1'b0, 18'h2A5F3, 17'h12345, 1'b1);
		for (k = 1; k < 16; k++) begin
			if (k < 2 || k > 4) u_ssc_host.send({4'(k), 18'h3FFFF}, 0);
		end
		expect_out(8'h41, 1'b0, 1'b0, 18'h2A5F3, 17'h12345, 1'b1);
		u_ssc_host.send({4'h3, 18'h00400}, 0);
		expect_out(8'h41, 1'b0, 1'b0, 18'h00400, 17'h12345, 1'b0);
		$display("Test divide values done");
		@(negedge sys_clk_i);
		chk("strobe count", 47'(n_strobe), 47'h16);
		final_report();
	end
endmodule : ssc_regs_tb
`default_nettype wire
